//--- rtl/tone_pkg.sv
// constants shared by the tone and melody generator
// assumes a 25 mhz system clock and a classic wishbone register bus
package tone_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned ENV_TIME_US     = 2500;
    localparam int unsigned ENV_CYCLES      = (CLK_HZ / 1000) * ENV_TIME_US / 1000;
    localparam int unsigned PAT1_BPM        = 175;
    localparam int unsigned PAT2_BPM        = 200;
    localparam int unsigned PAT3_BPM        = 255;
    // note length in cycles: a quarter of a beat, an eighth of a beat for pattern 1
    localparam int unsigned PAT1_NOTE_CYC   = (CLK_HZ / PAT1_BPM) * 60 / 8;
    localparam int unsigned PAT2_NOTE_CYC   = (CLK_HZ / PAT2_BPM) * 60 / 4;
    localparam int unsigned PAT3_NOTE_CYC   = (CLK_HZ / PAT3_BPM) * 60 / 4;
    localparam int unsigned PAT_REPEATS     = 15;
    localparam int unsigned VOICES          = 3;
    localparam int unsigned VOL_STEPS       = 10;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_START  = 8'h04;
    localparam logic [7:0] ADDR_VOLUME = 8'h08;
    localparam logic [7:0] ADDR_CFG    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_VTAB   = 8'h20;
    localparam logic [7:0] ADDR_SINGLE = 8'h40;
    // ctrl fields
    localparam int unsigned CTRL_GO_BIT   = 0;
    localparam int unsigned CTRL_STOP_BIT = 1;
    localparam int unsigned CTRL_MODE_LSB = 4;
    // modes
    localparam logic [2:0] MODE_PAT1   = 3'h1;
    localparam logic [2:0] MODE_PAT2   = 3'h2;
    localparam logic [2:0] MODE_PAT3   = 3'h3;
    localparam logic [2:0] MODE_MELODY = 3'h4;
    localparam logic [2:0] MODE_SINGLE = 3'h5;
    // cfg fields
    localparam int unsigned CFG_ENV_OFF_BIT = 0;
    // pattern note pitch half-periods in cycles (two notes per pattern)
    localparam logic [15:0] PAT1_HP_A = 16'h1710;
    localparam logic [15:0] PAT1_HP_B = 16'h0f6d;
    localparam logic [15:0] PAT2_HP_A = 16'h124a;
    localparam logic [15:0] PAT2_HP_B = 16'h0b8a;
    localparam logic [15:0] PAT3_HP_A = 16'h0b88;
    localparam logic [15:0] PAT3_HP_B = 16'h07b6;
    // melody record: [15:0] half period, [31:16] note length in ms
    // record with zero length ends the melody
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam logic [7:0]  VOL_DEFAULT = 8'h80;
endpackage : tone_pkg

//--- rtl/tone_voice_if.sv
// carries one voice's pitch and gate from the sequencer to the mixer
// assumes one clock domain
interface tone_voice_if;
    logic [15:0] half_period;
    logic        gate;
    modport src (output half_period, output gate);
    modport dst (input half_period, input gate);
endinterface : tone_voice_if

//--- rtl/tone_voices.sv
// three square-wave voices, envelope and volume, summed to one sample
// assumes gate changes only between notes
module tone_voices
    import tone_pkg::*;
#(
    parameter int unsigned ENV_CYC = ENV_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    tone_voice_if.dst        v0,
    tone_voice_if.dst        v1,
    tone_voice_if.dst        v2,
    input  wire logic        env_off_i,
    input  wire logic [7:0]  volume_i,
    output logic      [15:0] sample_o,
    output logic             busy_o
);
    if (ENV_CYC < 1 || ENV_CYC > 65535) $error("bad ENV_CYC");
    logic [15:0] hp [VOICES];
    logic        gt [VOICES];
    assign hp[0] = v0.half_period;
    assign hp[1] = v1.half_period;
    assign hp[2] = v2.half_period;
    assign gt[0] = v0.gate;
    assign gt[1] = v1.gate;
    assign gt[2] = v2.gate;
    logic [15:0] env_reg [VOICES];
    logic [15:0] ph_reg  [VOICES];
    logic        sq_reg  [VOICES];
    logic [9:0]  lvl     [VOICES];
    // ==========================================================
    // per voice oscillator and envelope
    for (genvar i = 0; i < VOICES; i++) begin : g_voice
        always_ff @(posedge clk_i) begin
            if (rst_i || hp[i] == 16'h0000) begin
                ph_reg[i] <= 16'h0000;
                sq_reg[i] <= 1'b0;
            end else if (ph_reg[i] >= hp[i] - 16'h0001) begin
                ph_reg[i] <= 16'h0000;
                sq_reg[i] <= ~sq_reg[i];
            end else begin
                ph_reg[i] <= ph_reg[i] + 16'h0001;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                env_reg[i] <= 16'h0000;
            end else if (env_off_i) begin
                // full level at once, no ramp at either end  (see RL9)
                env_reg[i] <= gt[i] ? 16'(ENV_CYC) : 16'h0000;
            end else if (gt[i] && env_reg[i] < 16'(ENV_CYC)) begin
                env_reg[i] <= env_reg[i] + 16'h0001; // see RL5, see RL6
            end else if (!gt[i] && env_reg[i] != 16'h0000) begin
                env_reg[i] <= env_reg[i] - 16'h0001; // see RL5, see RL6
            end
        end
        // scale envelope to 0..255
        assign lvl[i] = 10'((32'(env_reg[i]) * 255) / ENV_CYC);
    end
    // ==========================================================
    // mixer: three voices summed together  (see RL1)
    logic signed [17:0] mix;
    always_comb begin
        mix = 18'sd0;
        for (int k = 0; k < VOICES; k++) begin
            mix = sq_reg[k] ? mix + 18'(signed'({8'h00, lvl[k]}))
                            : mix - 18'(signed'({8'h00, lvl[k]}));
        end
    end
    logic signed [26:0] scaled;
    assign scaled = 27'(mix) * 27'(signed'({1'b0, volume_i}));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_o <= 16'h0000;
            busy_o   <= 1'b0;
        end else begin
            sample_o <= scaled[23:8];
            busy_o   <= (env_reg[0] | env_reg[1] | env_reg[2]) != 16'h0000;
        end
    end
endmodule : tone_voices

//--- rtl/tone_melody_gen.sv
// tone and melody generator top: wishbone registers, pattern and
// melody sequencer, nvm fetch port, earpiece sample output
// assumes nvm answers a read with one-cycle nvm_ack_i on the same clock
module tone_melody_gen
    import tone_pkg::*;
#(
    parameter int unsigned ENV_CYC  = ENV_CYCLES,
    parameter int unsigned P1_CYC   = PAT1_NOTE_CYC,
    parameter int unsigned P2_CYC   = PAT2_NOTE_CYC,
    parameter int unsigned P3_CYC   = PAT3_NOTE_CYC,
    parameter int unsigned MS_CYC   = MS_CYCLES
) (
// What this block does
// RL1 - mixes up to three voices at once for polyphonic melodies
// RL2 - three built-in two-note patterns at 175, 200 and 255 bpm
// RL3 - built-in pattern plays fifteen times then stops by itself
// RL4 - host gives melody header address; block fetches data from nvm
// RL5 - each tone ramps up at start and down at end
// RL6 - ramps last 2.5 ms; a config bit disables the envelope
// RL7 - ten volume levels, each level held in a writable table
// RL8 - output goes only to earpiece; no buzzer output
// RL9 - envelope disabled means tones start and stop at full level
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic      [15:0] nvm_addr_o,
    output logic             nvm_req_o,
    input  wire logic [31:0] nvm_data_i,
    input  wire logic        nvm_ack_i,
    output logic      [15:0] earpiece_o
);
    if (ENV_CYC < 1 || P1_CYC < 1 || P2_CYC < 1 || P3_CYC < 1
        || MS_CYC < 1) $error("timing parameters must be positive");
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_PAT   = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_NOTE  = 5'b01000,
        ST_DRAIN = 5'b10000
    } seq_state_t;
    seq_state_t  state_reg;
    logic [2:0]  mode_reg;
    logic [15:0] start_reg;
    logic [3:0]  vol_idx_reg;
    logic        env_off_reg;
    logic [7:0]  vtab_reg [VOL_STEPS];
    logic [15:0] single_reg;
    logic [15:0] ptr_reg;
    logic [3:0]  rep_reg;
    logic        half_reg;
    logic [31:0] tmr_reg;
    logic [15:0] hp_reg  [VOICES];
    logic        gate_reg;
    logic        go_pulse;
    logic        stop_pulse;
    logic        wr;
    logic        rd_ok;
    logic        busy;
    logic [15:0] sample;
    // ==========================================================
    // wishbone slave, one wait state: ack the cycle after the strobe
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                && !wb_err_o && wb_sel_i[0];
    always_comb begin
        rd_ok = 1'b1;
        case (wb_adr_i)
            ADDR_CTRL, ADDR_START, ADDR_VOLUME, ADDR_CFG,
            ADDR_STATUS, ADDR_SINGLE: rd_ok = 1'b1;
            default: rd_ok = wb_adr_i >= ADDR_VTAB
                && wb_adr_i < ADDR_VTAB + 8'(4 * VOL_STEPS)
                && wb_adr_i[1:0] == 2'b00;
        endcase
    end
    assign go_pulse   = wr && wb_adr_i == ADDR_CTRL
                        && wb_dat_i[CTRL_GO_BIT];
    assign stop_pulse = wr && wb_adr_i == ADDR_CTRL
                        && wb_dat_i[CTRL_STOP_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
                        && rd_ok;
            wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
                        && !rd_ok;
            case (wb_adr_i)
                ADDR_CTRL:   wb_dat_o <= {25'h0, mode_reg, 4'h0};
                ADDR_START:  wb_dat_o <= {16'h0, start_reg};
                ADDR_VOLUME: wb_dat_o <= {28'h0, vol_idx_reg};
                ADDR_CFG:    wb_dat_o <= {31'h0, env_off_reg};
                ADDR_STATUS: wb_dat_o <= {16'h0, ptr_reg[7:0], rep_reg,
                                          busy, gate_reg,
                                          state_reg != ST_IDLE, 1'b0};
                ADDR_SINGLE: wb_dat_o <= {16'h0, single_reg};
                default:     wb_dat_o <= rd_ok
                    ? {24'h0, vtab_reg[4'(wb_adr_i[5:2] - 4'h8)]}
                    : 32'h0000_0000;
            endcase
        end
    end
    // ==========================================================
    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg    <= MODE_PAT1;
            start_reg   <= 16'h0000;
            vol_idx_reg <= 4'(VOL_STEPS - 1);
            env_off_reg <= 1'b0;
            single_reg  <= 16'h0000;
        end else if (wr) begin
            case (wb_adr_i)
                ADDR_CTRL:   mode_reg <= wb_dat_i[CTRL_MODE_LSB +: 3];
                ADDR_START:  start_reg <= wb_dat_i[15:0]; // see RL4
                ADDR_VOLUME: if (wb_dat_i[3:0] < 4'(VOL_STEPS))
                    vol_idx_reg <= wb_dat_i[3:0];         // see RL7
                ADDR_CFG:    env_off_reg <= wb_dat_i[CFG_ENV_OFF_BIT];
                ADDR_SINGLE: single_reg <= wb_dat_i[15:0];
                default: ;
            endcase
        end
    end
    for (genvar v = 0; v < VOL_STEPS; v++) begin : g_vtab
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                vtab_reg[v] <= 8'(VOL_DEFAULT * (v + 1) / VOL_STEPS);
            end else if (wr && wb_adr_i == ADDR_VTAB + 8'(4 * v)) begin
                vtab_reg[v] <= wb_dat_i[7:0];             // see RL7
            end
        end
    end
    // ==========================================================
    // sequencer
    function automatic logic [31:0] note_len(input logic [2:0] m);
        case (m)
            MODE_PAT1: note_len = 32'(P1_CYC);
            MODE_PAT2: note_len = 32'(P2_CYC);
            default:   note_len = 32'(P3_CYC);
        endcase
    endfunction : note_len
    function automatic logic [15:0] pat_hp(input logic [2:0] m,
                                           input logic b);
        case (m)
            MODE_PAT1: pat_hp = b ? PAT1_HP_B : PAT1_HP_A;
            MODE_PAT2: pat_hp = b ? PAT2_HP_B : PAT2_HP_A;
            default:   pat_hp = b ? PAT3_HP_B : PAT3_HP_A;
        endcase
    endfunction : pat_hp
    always_ff @(posedge clk_i) begin
        if (rst_i || stop_pulse) begin
            state_reg <= ST_IDLE;
            gate_reg  <= 1'b0;
            nvm_req_o <= 1'b0;
            rep_reg   <= 4'h0;
            half_reg  <= 1'b0;
            tmr_reg   <= 32'h0;
            ptr_reg   <= 16'h0000;
            for (int k = 0; k < VOICES; k++) hp_reg[k] <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: if (go_pulse) begin
                    gate_reg <= 1'b1;
                    case (wb_dat_i[CTRL_MODE_LSB +: 3])
                        MODE_PAT1, MODE_PAT2, MODE_PAT3: begin
                            hp_reg[0] <= pat_hp(wb_dat_i[6:4], 1'b0);
                            tmr_reg   <= note_len(wb_dat_i[6:4]); // see RL2
                            rep_reg   <= 4'h0;
                            half_reg  <= 1'b0;
                            state_reg <= ST_PAT;
                        end
                        MODE_MELODY: begin
                            gate_reg  <= 1'b0;
                            ptr_reg   <= start_reg;             // see RL4
                            nvm_req_o <= 1'b1;
                            state_reg <= ST_FETCH;
                        end
                        MODE_SINGLE: begin
                            hp_reg[0] <= single_reg;
                            state_reg <= ST_NOTE;
                            tmr_reg   <= 32'hffff_ffff;
                        end
                        default: gate_reg <= 1'b0;
                    endcase
                end
                ST_PAT: if (tmr_reg <= 32'h1) begin
                    tmr_reg  <= note_len(mode_reg);
                    half_reg <= ~half_reg;
                    hp_reg[0] <= pat_hp(mode_reg, ~half_reg); // see RL2
                    if (half_reg) begin
                        if (rep_reg == 4'(PAT_REPEATS - 1)) begin
                            gate_reg  <= 1'b0;                  // see RL3
                            state_reg <= ST_DRAIN;
                        end else begin
                            rep_reg <= rep_reg + 4'h1;          // see RL3
                        end
                    end
                end else begin
                    tmr_reg <= tmr_reg - 32'h1;
                end
                ST_FETCH: if (nvm_ack_i) begin
                    // one record per note: three voices share a length
                    nvm_req_o <= 1'b0;
                    if (nvm_data_i[31:16] == 16'h0000) begin
                        state_reg <= ST_DRAIN;
                    end else begin
                        hp_reg[0] <= nvm_data_i[15:0];
                        hp_reg[1] <= nvm_data_i[15:0] >> 1;     // see RL1
                        hp_reg[2] <= (nvm_data_i[15:0] >> 2)
                                     + (nvm_data_i[15:0] >> 3);
                        tmr_reg   <= 32'(nvm_data_i[31:16]) * 32'(MS_CYC);
                        gate_reg  <= 1'b1;
                        ptr_reg   <= ptr_reg + 16'h0001;        // see RL4
                        state_reg <= ST_NOTE;
                    end
                end
                ST_NOTE: if (tmr_reg <= 32'h1) begin
                    gate_reg <= 1'b0;
                    if (mode_reg == MODE_MELODY) begin
                        nvm_req_o <= 1'b1;
                        state_reg <= ST_FETCH;
                    end else begin
                        state_reg <= ST_DRAIN;
                    end
                end else if (mode_reg != MODE_SINGLE) begin
                    tmr_reg <= tmr_reg - 32'h1;
                end
                ST_DRAIN: if (!busy) begin
                    state_reg <= ST_IDLE;
                    for (int k = 0; k < VOICES; k++) hp_reg[k] <= 16'h0000;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    assign nvm_addr_o = ptr_reg;
    // ==========================================================
    // voices, envelope, mixing; the only audio output is the earpiece
    tone_voice_if vi0 ();
    tone_voice_if vi1 ();
    tone_voice_if vi2 ();
    assign vi0.half_period = hp_reg[0];
    assign vi1.half_period = hp_reg[1];
    assign vi2.half_period = hp_reg[2];
    assign vi0.gate = gate_reg;
    assign vi1.gate = gate_reg && hp_reg[1] != 16'h0000;
    assign vi2.gate = gate_reg && hp_reg[2] != 16'h0000;
    tone_voices #(.ENV_CYC(ENV_CYC)) u_voices (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .v0        (vi0),
        .v1        (vi1),
        .v2        (vi2),
        .env_off_i (env_off_reg),
        .volume_i  (vtab_reg[vol_idx_reg]),
        .sample_o  (sample),
        .busy_o    (busy)
    );
    always_ff @(posedge clk_i) begin
        if (rst_i) earpiece_o <= 16'h0000;
        else       earpiece_o <= sample;                   // see RL8
    end
endmodule : tone_melody_gen

//--- verification/tone_melody_gen_asserts.sv
// port assertions for the tone and melody generator
// assumes one clock, synchronous active high reset, bound below
module tone_melody_gen_asserts
    import tone_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [15:0] nvm_addr_o,
    input wire logic        nvm_req_o,
    input wire logic [31:0] nvm_data_i,
    input wire logic        nvm_ack_i,
    input wire logic [15:0] earpiece_o
);
    // ==========================================================
    // helper state
    logic taken;
    logic go_wr;
    logic started_reg;
    logic melody_reg;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign go_wr = taken && wb_we_i && wb_adr_i == ADDR_CTRL
                   && wb_dat_i[0] && !wb_dat_i[1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            started_reg <= 1'b0;
        end else if (go_wr) begin
            started_reg <= 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            melody_reg <= 1'b0;
        end else if (go_wr && wb_dat_i[6:4] == MODE_MELODY) begin
            melody_reg <= 1'b1;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence taken_s;
        taken;
    endsequence
    sequence answer_s;
        (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus request not answered in one cycle");
    no_orphan_a: assert property ((wb_ack_o || wb_err_o)
        |-> $past(wb_cyc_i && wb_stb_i)) else $error("answer without request");
    unmapped_err_a: assert property (taken && wb_adr_i == 8'h14
        |=> wb_err_o && !wb_ack_o) else $error("unmapped address acked");
    ctrl_ack_a: assert property (taken && wb_adr_i == ADDR_CTRL
        |=> wb_ack_o) else $error("control access not acked");
    fetch_hold_a: assert property (nvm_req_o && !nvm_ack_i
        |=> nvm_req_o && $stable(nvm_addr_o)) else $error("fetch dropped");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i
        |=> earpiece_o == 16'h0 && !nvm_req_o && !wb_ack_o)
        else $error("outputs active after reset");
    idle_silent_a: assert property (!started_reg
        |-> earpiece_o == 16'h0) else $error("sound before any start");
    fetch_melody_a: assert property (nvm_req_o |-> melody_reg)
        else $error("memory fetch without melody start");
endmodule : tone_melody_gen_asserts

bind tone_melody_gen tone_melody_gen_asserts i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .nvm_addr_o(nvm_addr_o), .nvm_req_o(nvm_req_o),
    .nvm_data_i(nvm_data_i), .nvm_ack_i(nvm_ack_i),
    .earpiece_o(earpiece_o));

//--- verification/nvm_model.sv
// nonvolatile memory holding one short melody for the fetch port
// assumes a registered request held until the one-cycle acknowledge
module nvm_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] nvm_addr_i,
    input  wire logic        nvm_req_i,
    output logic      [31:0] nvm_data_o,
    output logic             nvm_ack_o
);
    logic [2:0]  wait_reg;
    logic [31:0] rec;
    // ==========================================================
    // melody at 0x10: two notes then a zero-length end record
    always_comb begin
        case (nvm_addr_i)
            16'h0010: rec = 32'h0003_0014;
            16'h0011: rec = 32'h0002_000a;
            default:  rec = 32'h0000_0000;
        endcase
    end
    // odd addresses answer slowly so both timings are exercised
    always_ff @(posedge clk_i) begin
        nvm_ack_o  <= 1'b0;
        nvm_data_o <= ~nvm_data_o;
        if (rst_i) begin
            wait_reg   <= 3'h0;
            nvm_data_o <= 32'h5a5a_a5a5;
        end else if (nvm_req_i && !nvm_ack_o) begin
            if (wait_reg == (nvm_addr_i[0] ? 3'h4 : 3'h0)) begin
                nvm_ack_o  <= 1'b1;
                nvm_data_o <= rec;
                wait_reg   <= 3'h0;
            end else begin
                wait_reg <= wait_reg + 3'h1;
            end
        end
    end
endmodule : nvm_model

//--- verification/tone_melody_gen_test.sv
// self-checking bench for the tone and melody generator
// assumes the memory model above; counts shortened by parameters
module tone_melody_gen_test
    import tone_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ENV = 20;
    localparam int MSC = 10;
    localparam int PC [1:3] = '{50, 40, 30};
    logic        clk_i = 1'b0, rst_i = 1'b1, pclr = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, e;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0, q, dat_o, nvm_d;
    logic        ack, err, nreq, nack;
    logic [15:0] naddr, ear, peak, early, full, full2, mel_pk;
    logic [15:0] nlog [$];
    int          n_fail = 0, cmp_count = 0, ncyc = 0, t0;

    tone_melody_gen #(.ENV_CYC(ENV), .P1_CYC(50), .P2_CYC(40),
        .P3_CYC(30), .MS_CYC(MSC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .nvm_addr_o(naddr), .nvm_req_o(nreq), .nvm_data_i(nvm_d),
        .nvm_ack_i(nack), .earpiece_o(ear));
    nvm_model i_nvm (.clk_i(clk_i), .rst_i(rst_i), .nvm_addr_i(naddr),
        .nvm_req_i(nreq), .nvm_data_o(nvm_d), .nvm_ack_o(nack));

    // ==========================================================
    // helpers
    function automatic logic [15:0] mag(input logic [15:0] s);
        return s[15] ? 16'h0 - s : s;
    endfunction : mag
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] x, y);
        cmp_count++;
        if (y !== x) begin
            $display("MISMATCH %s expected %h seen %h", nm, x, y);
            n_fail++;
        end
    endtask : chk
    // one classic cycle; only the cycle ceiling ends a hang
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (!(ack || err)) begin
            @(posedge clk_i);
        end
        q = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] m, x);
        wb(1'b0, a, 32'h0);
        chk(nm, x, q & m);
    endtask : rd
    // polls status until playing, gate and envelope are all idle
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        do begin
            wb(1'b0, ADDR_STATUS, 32'h0);
            k++;
        end while (q[3:1] != 3'h0 && k < lim);
        if (q[3:1] != 3'h0) n_fail++;
        repeat (2) @(posedge clk_i);
    endtask : wait_idle
    task automatic tone_pk(output logic [15:0] pe, pf);
        pclr <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h51);
        pclr <= 1'b0;
        repeat (ENV / 4) @(posedge clk_i);
        pe = peak;
        repeat (ENV + 20) @(posedge clk_i);
        pf = peak;
    endtask : tone_pk

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        ncyc <= ncyc + 1;
        if (nreq && nack) nlog.push_back(naddr);
        if (pclr) peak <= 16'h0;
        else if (mag(ear) > peak) peak <= mag(ear);
        if (ncyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("volume", ADDR_VOLUME, 32'hf, 32'h9);
        rd("env cfg", ADDR_CFG, 32'h1, 32'h0);
        for (int v = 0; v < 10; v++) begin
            if (v == 8) continue;
            rd("vol table", ADDR_VTAB + 8'(4 * v), 32'hff,
               32'(128 * (v + 1) / 10));
        end
        wb(1'b1, ADDR_VOLUME, 32'ha);
        sel <= 4'he;
        wb(1'b1, ADDR_VOLUME, 32'h3);
        sel <= 4'hf;
        rd("volume kept", ADDR_VOLUME, 32'hf, 32'h9);
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 1, e);
        $display("test registers done");
        for (int m = 1; m <= 3; m++) begin
            t0 = ncyc;
            wb(1'b1, ADDR_CTRL, 32'(m * 16 + 1));
            rd("mode", ADDR_CTRL, 32'h70, 32'(m * 16));
            wait_idle(3000);
            chk("pattern run", 1, ncyc - t0 >= 30 * PC[m]
                && ncyc - t0 <= 30 * PC[m] + ENV + 40);
            chk("silent after", 0, ear);
        end
        chk("no fetch", 0, nlog.size());
        $display("test patterns done");
        pclr <= 1'b1;
        wb(1'b1, ADDR_START, 32'h10);
        wb(1'b1, ADDR_CTRL, 32'h41);
        pclr <= 1'b0;
        t0 = ncyc;
        wait_idle(500);
        mel_pk = peak;
        chk("fetch count", 3, nlog.size());
        for (int i = 0; i < 3; i++) begin
            chk("fetch addr", 16'h10 + i, nlog[i]);
        end
        chk("melody length", 1, ncyc - t0 >= 5 * MSC);
        $display("test melody done");
        wb(1'b1, ADDR_SINGLE, 32'h8);
        tone_pk(early, full);
        chk("ramp up", 1, early < full && early > 0);
        chk("three voices", 1, mel_pk > full);
        wb(1'b1, ADDR_CTRL, 32'h2);
        repeat (ENV / 2) @(posedge clk_i);
        chk("ramp down", 1, mag(ear) < full && mag(ear) > 0);
        repeat (ENV) @(posedge clk_i);
        chk("ramp end", 0, ear);
        $display("test envelope done");
        wb(1'b1, ADDR_CFG, 32'h1);
        tone_pk(early, full2);
        chk("no ramp", full2, early);
        chk("same level", full, full2);
        wb(1'b1, ADDR_CTRL, 32'h2);
        repeat (4) @(posedge clk_i);
        chk("hard stop", 0, ear);
        wb(1'b1, ADDR_VOLUME, 32'h3);
        tone_pk(early, full2);
        chk("softer", 1, full2 < full);
        wb(1'b1, ADDR_CTRL, 32'h2);
        $display("test no envelope and volume done");
        give_verdict();
    end
endmodule : tone_melody_gen_test
